/* File: design/usm_pkg.sv */
// constants shared by the asynchronous serial channel
package usm_pkg;

  // ==========================================================
  // register indices; the byte address is four times the index
  localparam logic [7:0] USM_IDX_TRANSMIT_BUFFER = 8'hA2;
  localparam logic [7:0] USM_IDX_RECEIVE_BUFFER = 8'hA6;
  localparam logic [7:0] USM_IDX_MODE = 8'hA0;
  localparam logic [7:0] USM_IDX_BAUD = 8'hA1;
  localparam logic [7:0] USM_IDX_CTRL0 = 8'hA4;
  localparam logic [7:0] USM_IDX_CTRL1 = 8'hA5;
  localparam logic [7:0] USM_IDX_PIN_ROUTE = 8'hF5;
  localparam int USM_ADDR_W = 10;

  // ==========================================================
  // channel_mode_register fields
  localparam int USM_MODE_SMD_LSB = 0;
  localparam int USM_MODE_CLOCK_SOURCE_SELECT = 3;
  localparam int USM_MODE_STPS = 4;
  localparam int USM_MODE_PRY = 5;
  localparam int USM_MODE_PRYE = 6;
  localparam logic [2:0] USM_SMD_7BIT = 3'h4;
  localparam logic [2:0] USM_SMD_8BIT = 3'h5;
  localparam logic [2:0] USM_SMD_9BIT = 3'h6;

  // ==========================================================
  // control 0: count source, transmit empty, open drain
  localparam int USM_C0_CLK_LSB = 0;
  localparam int USM_C0_TXEPT = 3;
  localparam int USM_C0_NCH = 5;
  localparam logic [1:0] USM_SRC_F1 = 2'h0;
  localparam logic [1:0] USM_SRC_F8 = 2'h1;
  localparam logic [1:0] USM_SRC_F32 = 2'h2;
  localparam logic [4:0] USM_PRESCALE_F8_LAST = 5'h07;
  localparam logic [4:0] USM_PRESCALE_F32_LAST = 5'h1F;

  // ==========================================================
  // control 1: enables and flags
  localparam int USM_C1_TE = 0;
  localparam int USM_C1_TI = 1;
  localparam int USM_C1_RE = 2;
  localparam int USM_C1_RI = 3;

  // ==========================================================
  // pin route register
  localparam int USM_PR_CH1_ROUTE = 0;
  localparam int USM_PR_CLK_ROUTE_LO = 1;
  localparam int USM_PR_CLK_ROUTE_HI = 2;
  localparam int USM_PR_CLK_DIR = 3;
  localparam logic [1:0] USM_CLK_ROUTE_NONE = 2'h0;
  localparam logic [1:0] USM_CLK_ROUTE_A = 2'h1;
  localparam logic [1:0] USM_CLK_ROUTE_B = 2'h2;

  // ==========================================================
  // receive buffer error flag positions
  localparam int USM_RB_OER = 12;
  localparam int USM_RB_FER = 13;
  localparam int USM_RB_PER = 14;
  localparam int USM_RB_SUM = 15;

  // ==========================================================
  // reset values and bit timing
  localparam logic [7:0] USM_MODE_RESET = 8'h00;
  localparam logic [7:0] USM_BAUD_RESET = 8'h00;
  localparam logic [7:0] USM_CTRL0_RESET = 8'h00;
  localparam logic [3:0] USM_PIN_ROUTE_RESET = 4'h0;
  localparam logic [3:0] USM_OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] USM_MID_SAMPLE = 4'h7;

  typedef enum logic [4:0] {
    USM_IDLE = 5'b00001,
    USM_START = 5'b00010,
    USM_DATA = 5'b00100,
    USM_PARITY = 5'b01000,
    USM_STOP = 5'b10000
  } usm_state_type;

endpackage

/* File: design/usm_baud_gen.sv */
// count source selection and baud divider giving the 16x bit tick
`timescale 1ns/10ps
`default_nettype none
module usm_baud_gen
  import usm_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // configuration
  input wire logic [1:0] i_src_sel,
  input wire logic i_ext_sel,
  input wire logic i_ext_rise,
  input wire logic [7:0] i_divisor,
  // tick out
  output logic o_tick16
);

  logic [4:0] pre_q;
  logic [7:0] div_q;
  logic src_en;

  // ==========================================================
  // prescaler for f1, f8, f32
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pre_q <= 5'h00;
    end else begin
      pre_q <= pre_q + 5'h01;
    end
  end

  // the external pin skips the f8/f32 prescaler and goes straight to the same n+1 divider as the internal source
  always_comb begin
    if (i_ext_sel) begin
      src_en = i_ext_rise;
    end else begin
      unique case (i_src_sel)
        USM_SRC_F8: src_en = (pre_q[2:0] == USM_PRESCALE_F8_LAST[2:0]);
        USM_SRC_F32: src_en = (pre_q == USM_PRESCALE_F32_LAST);
        default: src_en = 1'b1;
      endcase
    end
  end

  // divide by n+1; the 16 of the bit rate is counted by the channel
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      div_q <= 8'h00;
      o_tick16 <= 1'b0;
    end else begin
      o_tick16 <= 1'b0;
      if (src_en) begin
        if (div_q == 8'h00) begin
          div_q <= i_divisor;
          o_tick16 <= 1'b1;
        end else begin
          div_q <= div_q - 8'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: design/usm_channel.sv */
// one asynchronous serial channel with its apb register file and pin routing
`timescale 1ns/10ps
`default_nettype none
module usm_channel
  import usm_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [USM_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // serial pins
  input wire logic i_serial_in_pin,
  output logic o_serial_out_pin,
  output logic o_serial_out_oe_n,
  output logic o_serial_in_level,
  // transfer clock pin candidates
  input wire logic i_transfer_clock_pin_a,
  input wire logic i_transfer_clock_pin_b
);

  // ==========================================================
  // helpers
  function automatic logic is_async(input logic [2:0] smd);
    is_async = (smd == USM_SMD_7BIT) || (smd == USM_SMD_8BIT) || (smd == USM_SMD_9BIT);
  endfunction

  function automatic logic [3:0] char_last(input logic [2:0] smd);
    unique case (smd)
      USM_SMD_7BIT: char_last = 4'h6;
      USM_SMD_9BIT: char_last = 4'h8;
      default: char_last = 4'h7;
    endcase
  endfunction

  function automatic logic hit(input logic [USM_ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  // ==========================================================
  // registers and state
  logic [7:0] mode_q;
  logic [7:0] baud_q;
  logic [7:0] ctrl0_q;
  logic te_q;
  logic re_q;
  logic ti_q;
  logic ri_q;
  logic [3:0] route_q;
  logic [8:0] tb_q;
  logic [8:0] rb_q;
  logic oer_q;
  logic fer_q;
  logic per_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  logic wr_en;
  logic rd_en;
  logic setup;
  logic async_mode;
  logic [3:0] clast;
  logic two_stop;
  logic par_en;
  logic par_even;
  logic tick16;

  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;
  assign async_mode = is_async(mode_q[USM_MODE_SMD_LSB +: 3]);
  assign clast = char_last(mode_q[USM_MODE_SMD_LSB +: 3]);
  assign two_stop = mode_q[USM_MODE_STPS];
  assign par_en = mode_q[USM_MODE_PRYE];
  assign par_even = mode_q[USM_MODE_PRY];

  // ==========================================================
  // pin synchronisers
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_prev_q;
  logic cka_s1_q;
  logic cka_s2_q;
  logic ckb_s1_q;
  logic ckb_s2_q;
  logic ck_prev_q;
  logic ck_sel;
  logic ck_rise;
  logic rx_line;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_prev_q <= 1'b1;
      cka_s1_q <= 1'b0;
      cka_s2_q <= 1'b0;
      ckb_s1_q <= 1'b0;
      ckb_s2_q <= 1'b0;
      ck_prev_q <= 1'b0;
    end else begin
      rx_s1_q <= i_serial_in_pin;
      rx_s2_q <= rx_s1_q;
      rx_prev_q <= rx_line;
      cka_s1_q <= i_transfer_clock_pin_a;
      cka_s2_q <= cka_s1_q;
      ckb_s1_q <= i_transfer_clock_pin_b;
      ckb_s2_q <= ckb_s1_q;
      ck_prev_q <= ck_sel;
    end
  end

  // the pin stays readable as a general input whatever the channel does
  assign o_serial_in_level = rx_s2_q;
  // without the route bit the receiver sees an idle line
  assign rx_line = route_q[USM_PR_CH1_ROUTE] ? rx_s2_q : 1'b1;

  // pick the routed clock pin; none routed means no edges
  always_comb begin
    unique case (route_q[USM_PR_CLK_ROUTE_HI:USM_PR_CLK_ROUTE_LO])
      USM_CLK_ROUTE_A: ck_sel = cka_s2_q;
      USM_CLK_ROUTE_B: ck_sel = ckb_s2_q;
      default: ck_sel = 1'b0;
    endcase
  end
  // pin is a transfer clock only when selected external and direction is input
  assign ck_rise = ck_sel && !ck_prev_q && mode_q[USM_MODE_CLOCK_SOURCE_SELECT] && !route_q[USM_PR_CLK_DIR];

  usm_baud_gen u_baud (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_src_sel(ctrl0_q[USM_C0_CLK_LSB +: 2]),
    .i_ext_sel(mode_q[USM_MODE_CLOCK_SOURCE_SELECT]),
    .i_ext_rise(ck_rise),
    .i_divisor(baud_q),
    .o_tick16(tick16)
  );

  // ==========================================================
  // transmitter
  usm_state_type tx_st_q;
  logic [3:0] tx_tick_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_sh_q;
  logic tx_par_q;
  logic tx_out_q;
  logic tx_load;
  logic tx_bit_end;

  assign tx_load = (tx_st_q == USM_IDLE) && async_mode && te_q && !ti_q;
  assign tx_bit_end = tick16 && (tx_tick_q == USM_OVERSAMPLE_LAST);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tx_st_q <= USM_IDLE;
      tx_tick_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h000;
      tx_par_q <= 1'b0;
      tx_out_q <= 1'b1;
    end else begin
      if (tick16) begin
        tx_tick_q <= tx_tick_q + 4'h1;
      end
      unique case (tx_st_q)
        USM_IDLE: begin
          tx_out_q <= 1'b1;
          if (tx_load) begin
            tx_sh_q <= tb_q;
            tx_par_q <= !par_even;
            tx_tick_q <= 4'h0;
            tx_out_q <= 1'b0;
            tx_st_q <= USM_START;
          end
        end
        USM_START: begin
          if (tx_bit_end) begin
            tx_out_q <= tx_sh_q[0];
            tx_par_q <= tx_par_q ^ tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[8:1]};
            tx_bit_q <= 4'h0;
            tx_st_q <= USM_DATA;
          end
        end
        USM_DATA: begin
          if (tx_bit_end) begin
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q != clast) begin
              tx_out_q <= tx_sh_q[0];
              tx_par_q <= tx_par_q ^ tx_sh_q[0];
              tx_sh_q <= {1'b0, tx_sh_q[8:1]};
            end else if (par_en) begin
              tx_out_q <= tx_par_q;
              tx_st_q <= USM_PARITY;
            end else begin
              tx_out_q <= 1'b1;
              tx_bit_q <= 4'h0;
              tx_st_q <= USM_STOP;
            end
          end
        end
        USM_PARITY: begin
          if (tx_bit_end) begin
            tx_out_q <= 1'b1;
            tx_bit_q <= 4'h0;
            tx_st_q <= USM_STOP;
          end
        end
        USM_STOP: begin
          if (tx_bit_end) begin
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q[0] == two_stop) begin
              tx_st_q <= USM_IDLE;
            end
          end
        end
        default: tx_st_q <= USM_IDLE;
      endcase
      if (!async_mode) begin
        tx_st_q <= USM_IDLE;
        tx_out_q <= 1'b1;
      end
    end
  end

  // pin is owned by the channel in async mode with the route bit set, even when only receiving
  // open drain releases the line instead of driving a one
  always_comb begin
    o_serial_out_pin = tx_out_q;
    if (!async_mode || !route_q[USM_PR_CH1_ROUTE]) begin
      o_serial_out_oe_n = 1'b1;
    end else if (ctrl0_q[USM_C0_NCH]) begin
      o_serial_out_oe_n = tx_out_q;
    end else begin
      o_serial_out_oe_n = 1'b0;
    end
  end

  // ==========================================================
  // receiver
  usm_state_type rx_st_q;
  logic [3:0] rx_tick_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_sh_q;
  logic rx_par_q;
  logic rx_perr_q;
  logic rx_ferr_q;
  logic rx_done;
  logic rx_sample;

  assign rx_sample = tick16 && (rx_tick_q == USM_OVERSAMPLE_LAST);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rx_st_q <= USM_IDLE;
      rx_tick_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_par_q <= 1'b0;
      rx_perr_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick16) begin
        rx_tick_q <= rx_tick_q + 4'h1;
      end
      unique case (rx_st_q)
        USM_IDLE: begin
          if (async_mode && re_q && rx_prev_q && !rx_line) begin
            rx_tick_q <= 4'h0;
            rx_sh_q <= 9'h000;
            rx_par_q <= !par_even;
            rx_ferr_q <= 1'b0;
            rx_st_q <= USM_START;
          end
        end
        USM_START: begin
          // half a bit in, a start bit that is gone was a glitch
          if (tick16 && rx_tick_q == USM_MID_SAMPLE) begin
            rx_tick_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_st_q <= rx_line ? USM_IDLE : USM_DATA;
          end
        end
        USM_DATA: begin
          if (rx_sample) begin
            rx_bit_q <= rx_bit_q + 4'h1;
            rx_par_q <= rx_par_q ^ rx_line;
            rx_sh_q[rx_bit_q] <= rx_line;
            if (rx_bit_q == clast) begin
              rx_bit_q <= 4'h0;
              rx_st_q <= par_en ? USM_PARITY : USM_STOP;
            end
          end
        end
        USM_PARITY: begin
          if (rx_sample) begin
            rx_perr_q <= (rx_par_q != rx_line);
            rx_st_q <= USM_STOP;
          end
        end
        USM_STOP: begin
          if (rx_sample) begin
            rx_bit_q <= rx_bit_q + 4'h1;
            if (!rx_line) begin
              rx_ferr_q <= 1'b1;
            end
            if (rx_bit_q[0] == two_stop) begin
              rx_done <= 1'b1;
              rx_st_q <= USM_IDLE;
            end
          end
        end
        default: rx_st_q <= USM_IDLE;
      endcase
      if (rx_st_q == USM_IDLE) begin
        rx_perr_q <= 1'b0;
      end
      if (!async_mode || !re_q) begin
        rx_st_q <= USM_IDLE;
      end
    end
  end

  // ==========================================================
  // apb register writes
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mode_q <= USM_MODE_RESET;
      baud_q <= USM_BAUD_RESET;
      ctrl0_q <= USM_CTRL0_RESET;
      te_q <= 1'b0;
      re_q <= 1'b0;
      route_q <= USM_PIN_ROUTE_RESET;
    end else if (wr_en && i_pstrb[0]) begin
      if (hit(i_paddr, USM_IDX_MODE)) begin
        mode_q <= i_pwdata[7:0];
      end
      if (hit(i_paddr, USM_IDX_BAUD)) begin
        baud_q <= i_pwdata[7:0];
      end
      if (hit(i_paddr, USM_IDX_CTRL0)) begin
        ctrl0_q <= i_pwdata[7:0];
      end
      if (hit(i_paddr, USM_IDX_CTRL1)) begin
        te_q <= i_pwdata[USM_C1_TE];
        re_q <= i_pwdata[USM_C1_RE];
      end
      if (hit(i_paddr, USM_IDX_PIN_ROUTE)) begin
        route_q <= i_pwdata[3:0];
      end
    end
  end

  // upper lane stores bit 8 only; the lower lane completes the character
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tb_q <= 9'h000;
      ti_q <= 1'b1;
    end else begin
      if (tx_load) begin
        ti_q <= 1'b1;
      end
      if (wr_en && hit(i_paddr, USM_IDX_TRANSMIT_BUFFER)) begin
        if (i_pstrb[1]) begin
          tb_q[8] <= i_pwdata[8];
        end
        if (i_pstrb[0]) begin
          tb_q[7:0] <= i_pwdata[7:0];
          ti_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // receive buffer and its flags
  logic rb_read;
  assign rb_read = rd_en && hit(i_paddr, USM_IDX_RECEIVE_BUFFER);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rb_q <= 9'h000;
      ri_q <= 1'b0;
      oer_q <= 1'b0;
      fer_q <= 1'b0;
      per_q <= 1'b0;
    end else begin
      // a word read always covers the upper byte, so it clears ri and the framing and parity flags; overrun clears only with re off
      if (rb_read) begin
        ri_q <= 1'b0;
        fer_q <= 1'b0;
        per_q <= 1'b0;
      end
      // a completion in the same cycle as the read wins over the clear
      if (rx_done) begin
        rb_q <= rx_sh_q;
        ri_q <= 1'b1;
        fer_q <= rx_ferr_q;
        per_q <= rx_perr_q;
        if (ri_q && !rb_read) begin
          oer_q <= 1'b1;
        end
      end else if (!re_q) begin
        oer_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // apb read path; data is captured in the setup cycle
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (hit(i_paddr, USM_IDX_RECEIVE_BUFFER)) begin
      // error bits come with the data in one word
      prdata_d[8:0] = rb_q;
      prdata_d[USM_RB_OER] = oer_q;
      prdata_d[USM_RB_FER] = fer_q;
      prdata_d[USM_RB_PER] = per_q;
      prdata_d[USM_RB_SUM] = oer_q || fer_q || per_q;
    end else if (hit(i_paddr, USM_IDX_MODE)) begin
      prdata_d[7:0] = mode_q;
    end else if (hit(i_paddr, USM_IDX_BAUD)) begin
      prdata_d[7:0] = baud_q;
    end else if (hit(i_paddr, USM_IDX_CTRL0)) begin
      prdata_d[7:0] = ctrl0_q;
      prdata_d[USM_C0_TXEPT] = (tx_st_q == USM_IDLE);
    end else if (hit(i_paddr, USM_IDX_CTRL1)) begin
      prdata_d[USM_C1_TE] = te_q;
      prdata_d[USM_C1_TI] = ti_q;
      prdata_d[USM_C1_RE] = re_q;
      prdata_d[USM_C1_RI] = ri_q;
    end else if (hit(i_paddr, USM_IDX_PIN_ROUTE)) begin
      prdata_d[3:0] = route_q;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= prdata_d;
    end
  end

  // no wait states; unmapped reads return zero and writes are dropped
  assign o_prdata = prdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;

endmodule
`default_nettype wire

/* File: tb/usm_channel_props.sv */
// port-level assertions for the serial channel
`timescale 1ns/10ps
`default_nettype none
module usm_channel_props
  import usm_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [USM_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // serial pins
  input wire logic i_serial_in_pin,
  input wire logic o_serial_out_pin,
  input wire logic o_serial_out_oe_n,
  input wire logic o_serial_in_level
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  logic rd_acc;
  assign rd_acc = i_psel && i_penable && !i_pwrite;
  // ==========================================================
  // bus answers
  AST_PREADY: assert property (i_psel && !i_penable |=> o_pready)
    else $error("access phase without ready");
  AST_NO_SLVERR: assert property (i_psel |-> !o_pslverr)
    else $error("slave error raised");
  AST_UNMAPPED_ZERO: assert property (rd_acc && i_paddr == 10'h3FC |-> o_prdata == 32'h0)
    else $error("unmapped read not zero");
  // ==========================================================
  // pins; a bit lasts at least 16 clocks, so 8 is a safe floor
  AST_RESET_IDLE: assert property (disable iff (1'b0) i_reset |=> o_serial_out_pin && o_serial_out_oe_n)
    else $error("output not idle after reset");
  AST_LOW_MIN: assert property ($fell(o_serial_out_pin) |=> !o_serial_out_pin [*8])
    else $error("low bit too short");
  AST_HIGH_MIN: assert property ($rose(o_serial_out_pin) |=> o_serial_out_pin [*8])
    else $error("high bit too short");
  AST_LOW_DRIVEN: assert property (!o_serial_out_pin |-> !o_serial_out_oe_n)
    else $error("low level not driven");
  AST_IN_LEVEL: assert property ($stable(i_serial_in_pin) [*4] |-> o_serial_in_level == i_serial_in_pin)
    else $error("input level not followed");
  cover property ($fell(o_serial_out_pin));
  cover property (rd_acc && i_paddr == {USM_IDX_RECEIVE_BUFFER, 2'h0});
  cover property ($fell(i_serial_in_pin));
endmodule
bind usm_channel usm_channel_props i_props (.i_clk_sys, .i_reset, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .i_serial_in_pin,
  .o_serial_out_pin, .o_serial_out_oe_n, .o_serial_in_level);
`default_nettype wire

/* File: tb/usm_peer.sv */
// remote asynchronous serial peer: sends and samples frames
`timescale 1ns/10ps
`default_nettype none
module usm_peer (
  // clock and line
  input wire logic i_clk_sys,
  input wire logic i_line,
  output logic o_line
);
  int bit_clks = 16;
  initial o_line = 1'b1;
  task automatic put(input logic v, input int len);
    o_line <= v;
    repeat (len) @(posedge i_clk_sys);
  endtask
  // ==========================================================
  // par: bit1 enables, bit0 even; a spoiled stop is short so no false start follows
  task automatic send(input logic [8:0] d, input int nb, input logic [1:0] par,
      input logic stps, input logic bad_stop);
    put(1'b0, bit_clks);
    for (int i = 0; i < nb; i++) begin
      put(d[i], bit_clks);
    end
    if (par[1]) begin
      put(^d ^ ~par[0], bit_clks);
    end
    if (bad_stop) begin
      put(1'b0, bit_clks * 5 / 8);
      put(1'b1, bit_clks * 3 / 8);
    end else begin
      put(1'b1, bit_clks);
    end
    put(1'b1, stps ? 2 * bit_clks : bit_clks);
  endtask
  task automatic recv(input int nb, input logic pe, input logic stps, output logic [8:0] d,
      output logic p, output logic [1:0] st);
    d = 9'h000;
    p = 1'b0;
    st = 2'h3;
    while (i_line) begin
      @(posedge i_clk_sys);
    end
    repeat (bit_clks / 2) @(posedge i_clk_sys);
    for (int i = 0; i < nb; i++) begin
      repeat (bit_clks) @(posedge i_clk_sys);
      d[i] = i_line;
    end
    if (pe) begin
      repeat (bit_clks) @(posedge i_clk_sys);
      p = i_line;
    end
    repeat (bit_clks) @(posedge i_clk_sys);
    st[1] = i_line;
    if (stps) begin
      repeat (bit_clks) @(posedge i_clk_sys);
      st[0] = i_line;
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the serial channel
`timescale 1ns/10ps
`default_nettype none
module testbench
  import usm_pkg::*;
();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] ext_on = 2'h0;
  logic [1:0] ck = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sout, soe_n, slevel, peer_tx, line;
  int bad_count = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  always @(posedge clk) ck <= ck + 2'h1;
  // released line is pulled up
  assign line = soe_n ? 1'b1 : sout;
  usm_channel i_usm_channel (.i_clk_sys(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_serial_in_pin(peer_tx),
    .o_serial_out_pin(sout), .o_serial_out_oe_n(soe_n), .o_serial_in_level(slevel),
    .i_transfer_clock_pin_a(ext_on[0] & ck[1]), .i_transfer_clock_pin_b(ext_on[1] & ck[1]));
  usm_peer i_usm_peer (.i_clk_sys(clk), .i_line(line), .o_line(peer_tx));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // apb transfer; two idle edges after it let registered pins settle
  task automatic apb(input logic [7:0] idx, input logic w, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    #5ms;
    bad_count++;
    conclude();
  end
  initial begin
    logic [31:0] r;
    logic [8:0] d, g;
    logic [7:0] m;
    logic [1:0] st, err, cr, src;
    logic p;
    int nb, n, mult;
    r = $urandom(91);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({soe_n, sout, slevel}, 3'h7);
    apb(8'hFF, 1'b0, 32'h0, 4'h0, r);
    chk(r, 32'h0);
    for (int k = 0; k < 7; k++) begin
      nb = (k < 3) ? 7 + k : 8;
      mult = (k == 3) ? 8 : (k == 4) ? 32 : (k > 4) ? 4 : 1;
      n = (k < 3) ? $urandom % 3 : 0;
      cr = (k > 4) ? 2'(k - 4) : USM_CLK_ROUTE_NONE;
      src = (k == 3 || k == 4) ? 2'(k - 2) : USM_SRC_F1;
      m = {1'b0, 1'($urandom), 1'($urandom), 1'($urandom), 1'(k > 4), 3'(nb - 3)};
      m[6] = m[6] | (k == 1);
      err = (k < 2) ? 2'(k + 1) : 2'($urandom);
      i_usm_peer.bit_clks = 16 * (n + 1) * mult;
      ext_on <= cr;
      apb(USM_IDX_PIN_ROUTE, 1'b1, {29'h0, cr, 1'b1}, 4'h1, r);
      apb(USM_IDX_BAUD, 1'b1, 32'(n), 4'h1, r);
      apb(USM_IDX_CTRL0, 1'b1, {26'h0, 1'b1, 3'h0, src}, 4'h1, r);
      apb(USM_IDX_MODE, 1'b1, {24'h0, m}, 4'h1, r);
      chk({soe_n, sout}, 2'h3);
      apb(USM_IDX_CTRL0, 1'b1, {30'h0, src}, 4'h1, r);
      chk({soe_n, sout}, 2'h1);
      apb(USM_IDX_CTRL1, 1'b1, 32'h5, 4'h1, r);
      d = 9'($urandom) & 9'((1 << nb) - 1);
      fork
        i_usm_peer.recv(nb, m[6], m[4], g, p, st);
        begin
          apb(USM_IDX_TRANSMIT_BUFFER, 1'b1, {23'h0, d[8], 8'h0}, 4'h2, r);
          apb(USM_IDX_TRANSMIT_BUFFER, 1'b1, {24'h0, d[7:0]}, 4'h1, r);
        end
      join
      chk(g, d);
      chk({p, st}, {m[6] & (^d ^ ~m[5]), 2'h3});
      i_usm_peer.send(d, nb, {m[6], m[5] ^ err[1]}, m[4], err[0]);
      repeat (4) @(posedge clk);
      apb(USM_IDX_RECEIVE_BUFFER, 1'b0, 32'h0, 4'h0, r);
      chk(r[8:0] & 9'((1 << nb) - 1), d);
      chk(r[15:12], {err[0] | (m[6] & err[1]), m[6] & err[1], err[0], 1'b0});
      apb(USM_IDX_RECEIVE_BUFFER, 1'b0, 32'h0, 4'h0, r);
      chk(r[14:13], 2'h0);
      apb(USM_IDX_CTRL1, 1'b0, 32'h0, 4'h0, r);
      chk(r[3:0], 4'h7);
    end
    // second frame lands while the first is unread
    repeat (2) i_usm_peer.send(d, nb, {m[6], m[5]}, m[4], 1'b0);
    apb(USM_IDX_RECEIVE_BUFFER, 1'b0, 32'h0, 4'h0, r);
    chk(r[15:12] & 4'h9, 4'h9);
    // dropping the route bit must release the driven output pin
    apb(USM_IDX_PIN_ROUTE, 1'b1, 32'h0, 4'h1, r);
    chk({31'h0, soe_n}, 32'h1);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({soe_n, sout}, 2'h3);
    apb(USM_IDX_MODE, 1'b0, 32'h0, 4'h0, r);
    chk(r[7:0], USM_MODE_RESET);
    apb(USM_IDX_CTRL1, 1'b0, 32'h0, 4'h0, r);
    chk(r[3:0], 4'h2);
    conclude();
  end
endmodule
`default_nettype wire
